/* shared/npr_defines.svh */
// Constants for the page NOR read and identification host controller
`ifndef NPR_DEFINES_SVH
`define NPR_DEFINES_SVH
// Software register offsets
`define NPR_OFF_CTRL      4'h0
`define NPR_OFF_ADDR      4'h1
`define NPR_OFF_STAT      4'h2
`define NPR_OFF_DATA      4'h3
`define NPR_OFF_PAGE0     4'h4
// Control register field positions
`define NPR_CTRL_GO       0
`define NPR_CTRL_OP_LO    1
`define NPR_CTRL_OP_HI    3
`define NPR_CTRL_ESUSP    4
// Status register field positions
`define NPR_STAT_BUSY     0
`define NPR_STAT_IDMODE   1
`define NPR_STAT_ESUSP    2
`define NPR_STAT_DONE     3
// Reset values
`define NPR_CTRL_RST      8'h00
`define NPR_ADDR_RST      23'h000000
// Command codes and unlock addresses (word mode)
`define NPR_CMD_UNLOCK1   8'hAA
`define NPR_CMD_UNLOCK2   8'h55
`define NPR_CMD_IDENT     8'h90
`define NPR_CMD_RESET     8'hF0
`define NPR_UNLOCK_ADR1   23'h000555
`define NPR_UNLOCK_ADR2   23'h0002AA
// Identification word offsets
`define NPR_ID_MFR        3'h0
`define NPR_ID_DEV1       3'h1
`define NPR_ID_PROT       3'h2
`define NPR_ID_IND        3'h3
`define NPR_ID_DEV2       4'hE
`define NPR_ID_DEV3       4'hF
// Page geometry
`define NPR_PAGE_WORDS    8
// Timing in ns and derived cycle counts at 20 MHz
`define NPR_CLK_NS        50
`define NPR_TAA_NS        110
`define NPR_TPA_NS        25
`define NPR_TWP_NS        50
`define NPR_TWPH_NS       30
`define NPR_TAA_CYC       ((`NPR_TAA_NS + `NPR_CLK_NS - 1) / `NPR_CLK_NS)
`define NPR_TPA_CYC       ((`NPR_TPA_NS + `NPR_CLK_NS - 1) / `NPR_CLK_NS)
`define NPR_TWP_CYC       ((`NPR_TWP_NS + `NPR_CLK_NS - 1) / `NPR_CLK_NS)
`define NPR_TWPH_CYC      ((`NPR_TWPH_NS + `NPR_CLK_NS - 1) / `NPR_CLK_NS)
`endif

/* shared/npr_pkg.sv */
// Types for the page NOR read and identification host controller
package npr_pkg;
  typedef enum logic [2:0] {
    NPR_OP_READ,
    NPR_OP_PAGE,
    NPR_OP_ID_ENTER,
    NPR_OP_ID_READ,
    NPR_OP_ID_EXIT
  } npr_op_t;

  // Flash pin bundle driven by the controller
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [22:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
  } npr_pins_t;

  // One bus cycle for the pin sequencer
  typedef struct packed {
    logic        wr;
    logic [22:0] addr;
    logic [15:0] data;
    logic        page;
  } npr_cyc_t;
endpackage : npr_pkg

/* design/npr_cycle.sv */
// Pin sequencer for one flash write, single read or page read
`timescale 1ns/1ns
`include "npr_defines.svh"
module npr_cycle
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Cycle request
  input  wire logic             start,
  input  wire npr_pkg::npr_cyc_t cyc,
  output logic                  done_r,
  output logic [15:0]           rdata_r,
  output logic [2:0]            widx_r,
  output logic                  wvalid_r,
  // Flash pins
  input  wire logic [15:0]      dq_in,
  output npr_pkg::npr_pins_t    pins_r
);
  typedef enum logic [2:0] {
    NPR_CY_IDLE, NPR_CY_WLOW, NPR_CY_WHIGH, NPR_CY_RACC, NPR_CY_PAGE, NPR_CY_END
  } npr_cy_st_t;

  npr_cy_st_t  st_r;
  logic [3:0]  cnt_r;
  logic [15:0] dq_s1_r;
  logic [15:0] dq_s2_r;
  logic        pg_r;

  // Two-flop synchroniser on the data bus
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
    end
    else
    begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
    end

  // Cycle state machine and pin drive
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      st_r     <= NPR_CY_IDLE;
      cnt_r    <= 4'h0;
      pg_r     <= 1'b0;
      done_r   <= 1'b0;
      wvalid_r <= 1'b0;
      widx_r   <= 3'h0;
      rdata_r  <= 16'h0000;
      pins_r   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 23'h000000,
                    dq_out: 16'h0000, dq_oe: 1'b0};
    end
    else
    begin
      done_r   <= 1'b0;
      wvalid_r <= 1'b0;
      unique case (st_r)
        NPR_CY_IDLE:
          if (start)
          begin
            pins_r.addr <= cyc.addr;
            pins_r.ce_n <= 1'b0;
            pg_r        <= cyc.page;
            if (cyc.wr)
            begin
              // Address taken at the later falling edge, data at rising edge
              pins_r.we_n   <= 1'b0;
              pins_r.dq_out <= cyc.data;
              pins_r.dq_oe  <= 1'b1;
              cnt_r         <= 4'(`NPR_TWP_CYC);
              st_r          <= NPR_CY_WLOW;
            end
            else
            begin
              // Read needs ce and oe low with we high
              pins_r.oe_n <= 1'b0;
              cnt_r       <= 4'(`NPR_TAA_CYC + 2);
              st_r        <= NPR_CY_RACC;
            end
          end
        NPR_CY_WLOW:
          if (cnt_r > 4'h1)
            cnt_r <= cnt_r - 4'h1;
          else
          begin
            pins_r.we_n <= 1'b1;
            pins_r.ce_n <= 1'b1;
            cnt_r       <= 4'(`NPR_TWPH_CYC);
            st_r        <= NPR_CY_WHIGH;
          end
        NPR_CY_WHIGH:
          if (cnt_r > 4'h1)
            cnt_r <= cnt_r - 4'h1;
          else
          begin
            pins_r.dq_oe <= 1'b0;
            st_r         <= NPR_CY_END;
          end
        NPR_CY_RACC:
          if (cnt_r > 4'h1)
            cnt_r <= cnt_r - 4'h1;
          else
          begin
            rdata_r  <= dq_s2_r;
            widx_r   <= pins_r.addr[2:0];
            wvalid_r <= 1'b1;
            if (pg_r && pins_r.addr[2:0] != 3'h7)
            begin
              // Only the word selector moves; upper lines stay put
              pins_r.addr[2:0] <= pins_r.addr[2:0] + 3'h1;
              cnt_r            <= 4'(`NPR_TPA_CYC + 2);
              st_r             <= NPR_CY_PAGE;
            end
            else
            begin
              pins_r.oe_n <= 1'b1;
              pins_r.ce_n <= 1'b1;
              st_r        <= NPR_CY_END;
            end
          end
        NPR_CY_PAGE:
          if (cnt_r > 4'h1)
            cnt_r <= cnt_r - 4'h1;
          else
          begin
            rdata_r  <= dq_s2_r;
            widx_r   <= pins_r.addr[2:0];
            wvalid_r <= 1'b1;
            if (pins_r.addr[2:0] != 3'h7)
            begin
              pins_r.addr[2:0] <= pins_r.addr[2:0] + 3'h1;
              cnt_r            <= 4'(`NPR_TPA_CYC + 2);
            end
            else
            begin
              pins_r.oe_n <= 1'b1;
              pins_r.ce_n <= 1'b1;
              st_r        <= NPR_CY_END;
            end
          end
        NPR_CY_END:
        begin
          done_r <= 1'b1;
          st_r   <= NPR_CY_IDLE;
        end
        default:
          st_r <= NPR_CY_IDLE;
      endcase
    end
endmodule : npr_cycle

/* design/npr_host.sv */
// Host controller for page reads and identification of a parallel NOR flash
`timescale 1ns/1ns
`include "npr_defines.svh"
// Functional notes
// - Upper address stable during page read
// - Two unlock writes precede identify command
// - Reset command ends identification mode
// - Identify only in read or suspend-read
// - Identify is AA, 55, 90 then read
module npr_host
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Software register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata_r,
  // Flash pins
  output logic             ce_n_r,
  output logic             oe_n_r,
  output logic             we_n_r,
  output logic [22:0]      addr_r,
  output logic [15:0]      dq_out_r,
  output logic             dq_oe_r,
  input  wire logic [15:0] dq_in
);
  typedef enum logic [2:0] {
    NPR_HS_IDLE, NPR_HS_ISSUE, NPR_HS_WAIT, NPR_HS_NEXT
  } npr_hs_st_t;

  npr_hs_st_t         st_r;
  logic [7:0]         ctrl_r;
  logic [22:0]        tgt_r;
  npr_pkg::npr_op_t   op_r;
  logic [1:0]         step_r;
  logic               busy_r;
  logic               done_flag_r;
  logic               idmode_r;
  logic               esusp_r;
  logic [15:0]        data_r;
  logic [15:0]        page_r [`NPR_PAGE_WORDS];
  npr_pkg::npr_cyc_t  cyc_nxt;
  logic               start_r;
  logic               cy_done;
  logic [15:0]        cy_rdata;
  logic [2:0]         cy_widx;
  logic               cy_wvalid;
  npr_pkg::npr_pins_t pins;
  npr_pkg::npr_op_t   op_req;
  logic               go_req;

  assign op_req = npr_pkg::npr_op_t'(reg_wdata[`NPR_CTRL_OP_HI:`NPR_CTRL_OP_LO]);
  assign go_req = reg_wr && reg_addr == `NPR_OFF_CTRL && reg_wdata[`NPR_CTRL_GO] && !busy_r;

  // Bus cycle chosen for the current operation step
  always_comb
  begin
    cyc_nxt = '{wr: 1'b0, addr: tgt_r, data: 16'h0000, page: 1'b0};
    unique case (op_r)
      npr_pkg::NPR_OP_READ:
        cyc_nxt.page = 1'b0;
      npr_pkg::NPR_OP_PAGE:
        cyc_nxt.addr = {tgt_r[22:3], 3'h0};
      npr_pkg::NPR_OP_ID_READ:
        cyc_nxt.page = 1'b0;
      npr_pkg::NPR_OP_ID_ENTER:
      begin
        // Unlock, unlock, identify command
        cyc_nxt.wr = 1'b1;
        unique case (step_r)
          2'h0:
          begin
            cyc_nxt.addr = `NPR_UNLOCK_ADR1;
            cyc_nxt.data = {8'h00, `NPR_CMD_UNLOCK1};
          end
          2'h1:
          begin
            cyc_nxt.addr = `NPR_UNLOCK_ADR2;
            cyc_nxt.data = {8'h00, `NPR_CMD_UNLOCK2};
          end
          default:
          begin
            cyc_nxt.addr = `NPR_UNLOCK_ADR1;
            cyc_nxt.data = {8'h00, `NPR_CMD_IDENT};
          end
        endcase
      end
      npr_pkg::NPR_OP_ID_EXIT:
      begin
        cyc_nxt.wr   = 1'b1;
        cyc_nxt.data = {8'h00, `NPR_CMD_RESET};
      end
      default:
        cyc_nxt.page = 1'b0;
    endcase
    if (op_r == npr_pkg::NPR_OP_PAGE)
      cyc_nxt.page = 1'b1;
  end

  // Pin sequencer
  npr_cycle u_cycle
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (start_r),
    .cyc      (cyc_nxt),
    .done_r   (cy_done),
    .rdata_r  (cy_rdata),
    .widx_r   (cy_widx),
    .wvalid_r (cy_wvalid),
    .dq_in    (dq_in),
    .pins_r   (pins)
  );

  // Pins straight from sequencer flops; deselected between operations
  assign ce_n_r   = pins.ce_n;
  assign oe_n_r   = pins.oe_n;
  assign we_n_r   = pins.we_n;
  assign addr_r   = pins.addr;
  assign dq_out_r = pins.dq_out;
  assign dq_oe_r  = pins.dq_oe;

  // Control and address registers
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_r <= `NPR_CTRL_RST;
      tgt_r  <= `NPR_ADDR_RST;
    end
    else if (reg_wr && reg_addr == `NPR_OFF_CTRL)
      ctrl_r <= reg_wdata[7:0];
    else if (reg_wr && reg_addr == `NPR_OFF_ADDR && !busy_r)
      tgt_r <= reg_wdata[22:0];

  // Operation sequencer
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      st_r    <= NPR_HS_IDLE;
      op_r    <= npr_pkg::NPR_OP_READ;
      step_r  <= 2'h0;
      busy_r  <= 1'b0;
      start_r <= 1'b0;
    end
    else
    begin
      start_r <= 1'b0;
      unique case (st_r)
        NPR_HS_IDLE:
          if (go_req)
          begin
            op_r   <= op_req;
            step_r <= 2'h0;
            busy_r <= 1'b1;
            st_r   <= NPR_HS_ISSUE;
          end
        NPR_HS_ISSUE:
        begin
          start_r <= 1'b1;
          st_r    <= NPR_HS_WAIT;
        end
        NPR_HS_WAIT:
          if (cy_done)
            st_r <= NPR_HS_NEXT;
        NPR_HS_NEXT:
          if (op_r == npr_pkg::NPR_OP_ID_ENTER && step_r != 2'h2)
          begin
            step_r <= step_r + 2'h1;
            st_r   <= NPR_HS_ISSUE;
          end
          else
          begin
            busy_r <= 1'b0;
            st_r   <= NPR_HS_IDLE;
          end
        default:
          st_r <= NPR_HS_IDLE;
      endcase
    end

  // Mode tracking and completion flag
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      idmode_r    <= 1'b0;
      esusp_r     <= 1'b0;
      done_flag_r <= 1'b0;
    end
    else
    begin
      if (st_r == NPR_HS_NEXT && busy_r && !(op_r == npr_pkg::NPR_OP_ID_ENTER && step_r != 2'h2))
      begin
        done_flag_r <= 1'b1;
        if (op_r == npr_pkg::NPR_OP_ID_ENTER)
        begin
          idmode_r <= 1'b1;
          esusp_r  <= ctrl_r[`NPR_CTRL_ESUSP];
        end
        else if (op_r == npr_pkg::NPR_OP_ID_EXIT)
          idmode_r <= 1'b0;
      end
      else if (go_req)
        done_flag_r <= 1'b0;
    end

  // Read capture; identification words other than the device codes and word 9 keep only the low byte
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      data_r <= 16'h0000;
    else if (cy_wvalid && op_r == npr_pkg::NPR_OP_ID_READ)
      data_r <= (tgt_r[3:0] == `NPR_ID_DEV2 || tgt_r[3:0] == `NPR_ID_DEV3 ||
                 tgt_r[2:0] == `NPR_ID_DEV1) ? cy_rdata
                                             : {8'h00, cy_rdata[7:0]};
    else if (cy_wvalid)
      data_r <= cy_rdata;

  // Page word store indexed by word selector
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      for (int i = 0; i < `NPR_PAGE_WORDS; i++)
        page_r[i] <= 16'h0000;
    end
    else if (cy_wvalid && op_r == npr_pkg::NPR_OP_PAGE)
      page_r[cy_widx] <= cy_rdata;

  // Register read port, data one cycle after strobe
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      reg_rdata_r <= 32'h00000000;
    else if (reg_rd)
    begin
      if (reg_addr >= `NPR_OFF_PAGE0 && reg_addr < 4'(`NPR_OFF_PAGE0 + `NPR_PAGE_WORDS))
        reg_rdata_r <= {16'h0000, page_r[3'(reg_addr - `NPR_OFF_PAGE0)]};
      else
        unique case (reg_addr)
          `NPR_OFF_CTRL: reg_rdata_r <= {24'h000000, ctrl_r};
          `NPR_OFF_ADDR: reg_rdata_r <= {9'h000, tgt_r};
          `NPR_OFF_STAT: reg_rdata_r <= {28'h0000000, done_flag_r, esusp_r, idmode_r, busy_r};
          `NPR_OFF_DATA: reg_rdata_r <= {16'h0000, data_r};
          default:       reg_rdata_r <= 32'h00000000;
        endcase
    end
endmodule : npr_host

/* dv/npr_host_asserts.sv */
// Assertion checker for the NOR host pin and command sequencing
`timescale 1ns/1ns
module npr_host_asserts
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Flash pins
  input wire logic        ce_n_r,
  input wire logic        oe_n_r,
  input wire logic        we_n_r,
  input wire logic [22:0] addr_r,
  input wire logic [15:0] dq_out_r,
  input wire logic        dq_oe_r
);
  logic       we_q_r;
  logic [7:0] cmd_r;
  logic       wrise;

  // Write strobe rise marks the data latch point
  assign wrise = we_n_r && !we_q_r;

  // Last command byte seen at a write strobe rise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      we_q_r <= 1'b1;
      cmd_r  <= 8'h00;
    end
    else
    begin
      we_q_r <= we_n_r;
      if (wrise)
        cmd_r <= dq_out_r[7:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_bus_free; dq_oe_r |-> oe_n_r; endproperty
  a_bus_free: assert property (p_bus_free)
    else $error("host drives data during a read");
  property p_read_ctrl; !oe_n_r |-> !ce_n_r && we_n_r; endproperty
  a_read_ctrl: assert property (p_read_ctrl)
    else $error("read strobe without select");
  property p_write_ctrl; !we_n_r |-> !ce_n_r && oe_n_r && dq_oe_r; endproperty
  a_write_ctrl: assert property (p_write_ctrl)
    else $error("bad write strobe levels");
  property p_data_hold; wrise |-> dq_oe_r && $stable(dq_out_r); endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("write data not held at strobe rise");
  property p_read_hold; $fell(oe_n_r) |-> (!oe_n_r && !ce_n_r) [*3]; endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read ended before access time");
  property p_page_upper; !oe_n_r && !$past(oe_n_r) |-> $stable(addr_r[22:3]); endproperty
  a_page_upper: assert property (p_page_upper)
    else $error("upper address moved in a page read");
  property p_page_step;
    !ce_n_r && !$past(ce_n_r) && $changed(addr_r) |->
      addr_r[2:0] == $past(addr_r[2:0]) + 3'h1;
  endproperty
  a_page_step: assert property (p_page_step)
    else $error("page word order wrong");
  property p_unlock2; wrise && dq_out_r[7:0] == 8'h55 |-> cmd_r == 8'hAA; endproperty
  a_unlock2: assert property (p_unlock2)
    else $error("second unlock without first");
  property p_ident; wrise && dq_out_r[7:0] == 8'h90 |-> cmd_r == 8'h55; endproperty
  a_ident: assert property (p_ident)
    else $error("identify command without unlock");
endmodule : npr_host_asserts

bind npr_host npr_host_asserts chk_u (.clk(clk), .rst_n(rst_n), .ce_n_r(ce_n_r),
  .oe_n_r(oe_n_r), .we_n_r(we_n_r), .addr_r(addr_r), .dq_out_r(dq_out_r),
  .dq_oe_r(dq_oe_r));

/* dv/npr_flash_model.sv */
// Behavioural page NOR flash answering reads and identification
`timescale 1ns/1ns
module npr_flash_model
#(
  parameter int          T_ACC   = 100,
  parameter int          T_PG    = 25,
  parameter logic [7:0]  MFR_ID  = 8'hA1,    // Arbitrary
  parameter logic [15:0] DEV_ID1 = 16'h3A11, // Arbitrary
  parameter logic [15:0] DEV_ID2 = 16'h3A22, // Arbitrary
  parameter logic [15:0] DEV_ID3 = 16'h3A33, // Arbitrary
  parameter logic        FACT_LK = 1'b1,
  parameter logic        WP_LOW  = 1'b0
)
(
  // Flash controls
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic [22:0] addr,
  // Host data drive and resolved bus
  input wire logic [15:0] host_dq,
  input wire logic        host_oe,
  output logic [15:0]     dq_bus
);
  logic        id_r = 1'b0;
  logic [1:0]  seq_r = 2'h0;
  logic        wact = 1'b0;
  logic [22:0] wadr;
  logic [15:0] val;
  logic [15:0] dly;
  logic [15:0] last = 16'h0000;
  logic        drv;
  logic        drv_d;
  logic [15:0] dly_pg;
  logic [19:0] upr_d;
  logic        pg_hit;

  // Address taken on the later falling edge
  always @(negedge ce_n or negedge we_n)
    if (!ce_n && !we_n && oe_n)
    begin
      wact = 1'b1;
      wadr = addr;
    end

  // Data taken on the earlier rising edge, command decode
  always @(posedge ce_n or posedge we_n)
    if (wact)
    begin
      wact = 1'b0;
      if (host_dq[7:0] == 8'hF0)
        {id_r, seq_r} = 3'h0;
      else if (seq_r == 2'h0 && host_dq[7:0] == 8'hAA && wadr == 23'h000555)
        seq_r = 2'h1;
      else if (seq_r == 2'h1 && host_dq[7:0] == 8'h55 && wadr == 23'h0002AA)
        seq_r = 2'h2;
      else if (seq_r == 2'h2 && host_dq[7:0] == 8'h90 && wadr == 23'h000555)
        {id_r, seq_r} = 3'h4;
      else
        seq_r = 2'h0;
    end

  // Array word or identification code; no page path in id mode
  always_comb
  begin
    val = addr[15:0] ^ 16'h5A3C;
    if (id_r)
      case (addr[3:0])
        4'h0: val = {8'hC3, MFR_ID};
        4'h1: val = DEV_ID1;
        4'hE: val = DEV_ID2;
        4'hF: val = DEV_ID3;
        4'h2: val = {15'h6180, addr[16] | addr[17]};
        4'h3: val = {8'hC3, FACT_LK, 2'b00, WP_LOW, 4'b1001};
        default: val = 16'hFFFF;
      endcase
  end

  // Data valid one access time after select; held while steady
  assign drv = !ce_n && !oe_n && we_n;
  assign #T_ACC dly = val;
  assign #T_ACC drv_d = drv;
  // Page hit: selected a full access time with steady upper lines, not in id mode
  assign #T_PG dly_pg = val;
  assign #T_ACC upr_d = addr[22:3];
  assign pg_hit = !id_r && drv_d && upr_d == addr[22:3];
  assign dq_bus = host_oe ? host_dq : (drv && drv_d) ? (pg_hit ? dly_pg : dly) : ~last;

  // Remember last driven value for the released bus
  always @(dq_bus)
    if (drv && drv_d)
      last = dq_bus;
endmodule : npr_flash_model

/* dv/tb_top.sv */
// Self-checking testbench for the NOR page read and identification host
`timescale 1ns/1ns
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata_r;
  logic        ce_n_r;
  logic        oe_n_r;
  logic        we_n_r;
  logic [22:0] addr_r;
  logic [15:0] dq_out_r;
  logic        dq_oe_r;
  logic [15:0] dq_in;
  logic [31:0] rd;
  int          num_errors = 0;
  int          checked = 0;

  npr_host dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .ce_n_r(ce_n_r),
    .oe_n_r(oe_n_r), .we_n_r(we_n_r), .addr_r(addr_r), .dq_out_r(dq_out_r),
    .dq_oe_r(dq_oe_r), .dq_in(dq_in));
  npr_flash_model flash_u (.ce_n(ce_n_r), .oe_n(oe_n_r), .we_n(we_n_r), .addr(addr_r),
    .host_dq(dq_out_r), .host_oe(dq_oe_r), .dq_bus(dq_in));

  // Clock at 20 MHz
  always #25 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata_r;
    @(posedge clk);
  endtask : reg_read

  // Poll status until idle; a poll limit that runs out shows as busy
  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      reg_read(4'h2, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
    check({30'h0, rd[3], rd[0]}, 32'h2);
  endtask : wait_idle

  task automatic run_op(input npr_pkg::npr_op_t op, input logic es, input logic [22:0] a);
    reg_write(4'h1, {9'h000, a});
    reg_write(4'h0, {27'h0, es, op, 1'b1});
    wait_idle();
  endtask : run_op

  task automatic t_read;
    run_op(npr_pkg::NPR_OP_READ, 1'b0, 23'h01234F);
    reg_read(4'h3, rd);
    check({16'h0, rd[15:0]}, {16'h0, 16'h234F ^ 16'h5A3C});
    // Go while busy and address write while busy are both dropped
    reg_write(4'h1, 32'h0000_7FF8);
    reg_write(4'h0, 32'h0000_0001);
    reg_write(4'h1, 32'h0000_1111);
    reg_write(4'h0, 32'h0000_0001);
    wait_idle();
    reg_read(4'h3, rd);
    check({16'h0, rd[15:0]}, {16'h0, 16'h7FF8 ^ 16'h5A3C});
    run_op(npr_pkg::NPR_OP_READ, 1'b0, 23'h7FFFF8);
    reg_read(4'h3, rd);
    check({16'h0, rd[15:0]}, {16'h0, 16'hFFF8 ^ 16'h5A3C});
  endtask : t_read

  task automatic t_page;
    run_op(npr_pkg::NPR_OP_PAGE, 1'b0, 23'h2AB3D5);
    for (int i = 0; i < 8; i++)
    begin
      reg_read(4'(4 + i), rd);
      check({16'h0, rd[15:0]}, {16'h0, {13'h167A, 3'(i)} ^ 16'h5A3C});
    end
    reg_read(4'hF, rd);
    check(rd, 32'h0);
  endtask : t_page

  task automatic t_ident;
    logic [22:0] ia [8] = '{23'h0, 23'h1, 23'hE, 23'hF, 23'h3, 23'h010002, 23'h020002,
                            23'h040002};
    logic [15:0] ie [8] = '{16'h00A1, 16'h3A11, 16'h3A22, 16'h3A33, 16'h0089, 16'h0001,
                            16'h0001, 16'h0000};
    logic [15:0] im [8] = '{16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF, 16'h00FF,
                            16'h00FF, 16'h00FF};
    run_op(npr_pkg::NPR_OP_ID_ENTER, 1'b0, 23'h0);
    reg_read(4'h2, rd);
    check({31'h0, rd[1]}, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      run_op(npr_pkg::NPR_OP_ID_READ, 1'b0, ia[i]);
      reg_read(4'h3, rd);
      check({16'h0, rd[15:0] & im[i]}, {16'h0, ie[i]});
    end
    run_op(npr_pkg::NPR_OP_ID_EXIT, 1'b0, 23'h0);
    run_op(npr_pkg::NPR_OP_READ, 1'b0, 23'h000003);
    reg_read(4'h3, rd);
    check({16'h0, rd[15:0]}, {16'h0, 16'h5A3F});
    // Entry from erase suspend is recorded; exit clears the id mode flag only
    run_op(npr_pkg::NPR_OP_ID_ENTER, 1'b1, 23'h0);
    reg_read(4'h2, rd);
    check({30'h0, rd[2:1]}, 32'h3);
    run_op(npr_pkg::NPR_OP_ID_EXIT, 1'b0, 23'h0);
    reg_read(4'h2, rd);
    check({31'h0, rd[1]}, 32'h0);
  endtask : t_ident

  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // Watchdog against a hung operation
  initial
  begin
    #1_500_000;
    num_errors++;
    conclude();
  end

  // Reset, then the scenarios in turn
  initial
  begin
    repeat (4) @(posedge clk);
    check({28'h0, ce_n_r, oe_n_r, we_n_r, dq_oe_r}, 32'hE);
    rst_n <= 1'b1;
    @(posedge clk);
    reg_read(4'h0, rd);
    check(rd, 32'h0);
    reg_read(4'h2, rd);
    check(rd, 32'h0);
    t_read();
    t_page();
    t_ident();
    conclude();
  end
endmodule : tb_top
